// >>> design/scfm_pkg.sv
package scfm_pkg;

    localparam int ADDR_W = 8;
    localparam int EVT_N  = 9;

    // register byte offsets
    localparam logic [7:0] OFS_STATUS    = 8'h00;
    localparam logic [7:0] OFS_MASK      = 8'h04;
    localparam logic [7:0] OFS_CODE      = 8'h08;
    localparam logic [7:0] OFS_SPEED_LIM = 8'h0C;
    localparam logic [7:0] OFS_CMD_LIM   = 8'h10;
    localparam logic [7:0] OFS_ALLOC_LO  = 8'h14;
    localparam logic [7:0] OFS_ALLOC_HI  = 8'h18;
    localparam logic [7:0] OFS_CLEAR     = 8'h1C;

    // status bit positions
    localparam int BIT_OVERSPEED2 = 0;
    localparam int BIT_CMD_ERR    = 1;
    localparam int BIT_CMD_GEN    = 2;
    localparam int BIT_CNT_OVF1   = 3;
    localparam int BIT_CNT_OVF2   = 4;
    localparam int BIT_DUP_LO     = 5;
    localparam int BIT_DUP_HI     = 6;
    localparam int BIT_FNUM_LO    = 7;
    localparam int BIT_FNUM_HI    = 8;

    // event codes, indexed by status bit
    localparam logic [EVT_N*32-1:0] EVT_CODES = {
        32'h3848_0000, 32'h3847_0000, 32'h3846_0000,
        32'h3845_0000, 32'h3844_0000, 32'h3843_0000,
        32'h3842_0000, 32'h3841_0000, 32'h3840_0000};

    // overflow limits
    localparam logic signed [63:0] OVF1_LIM       = 64'sh0000_0000_8000_0000;
    localparam logic signed [63:0] OVF2_PULSE_LIM = 64'sh0000_0000_2000_0000;
    localparam logic signed [63:0] OVF2_CMD_LIM   = 64'sh0000_0000_4000_0000;

    // allocation field layout, one byte per input
    localparam int ALLOC_FN_W    = 7;
    localparam int ALLOC_POL_BIT = 7;

    // reset values
    localparam logic [EVT_N-1:0] RST_STATUS    = 9'h000;
    localparam logic [EVT_N-1:0] RST_MASK      = 9'h000;
    localparam logic [31:0]      RST_SPEED_LIM = 32'hFFFF_FFFF;
    localparam logic [31:0]      RST_CMD_LIM   = 32'hFFFF_FFFF;
    localparam logic [31:0]      RST_ALLOC     = 32'h0000_0000;
    localparam logic [31:0]      RST_CODE      = 32'h0000_0000;

    typedef struct packed {
        logic [EVT_N-1:0] status;
        logic [EVT_N-1:0] mask;
        logic [31:0]      speed_lim;
        logic [31:0]      cmd_lim;
        logic [31:0]      alloc_lo;
        logic [31:0]      alloc_hi;
        logic [31:0]      rdata;
        logic [31:0]      code;
    } scfm_state_t;

endpackage : scfm_pkg

// >>> design/scfm_top.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module scfm_top #(
    parameter logic [6:0] FUNC_MAX = 7'h28
) (
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST_N,
    // register port
    input  wire logic [scfm_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [31:0]              WDATA,
    input  wire logic                     WR_STB,
    input  wire logic                     RD_STB,
    output logic      [31:0]              RDATA,
    output logic                          IRQ,
    // measurements from the motion path
    input  wire logic                     SAMPLE_VALID,
    input  wire logic signed [31:0]       MOTOR_SPEED,
    input  wire logic signed [31:0]       CMD_DELTA,
    input  wire logic                     CMD_CALC_FAULT,
    input  wire logic signed [63:0]       ABS_POS_CMD,
    input  wire logic signed [47:0]       FOLLOW_ERR_PULSE,
    input  wire logic signed [47:0]       FOLLOW_ERR_CMD,
    // latched fault view
    output logic                          FAULT_ACTIVE,
    output logic      [31:0]              FAULT_CODE
);
    import scfm_pkg::*;

    scfm_state_t state_r;
    scfm_state_t state_nxt;

    logic [EVT_N-1:0] events;
    logic [2:0]       grp_lo;
    logic [2:0]       grp_hi;
    logic [31:0]      code_now;
    logic [31:0]      speed_mag;
    logic [31:0]      delta_mag;
    logic             ovf1;
    logic             ovf2;
    logic signed [63:0] err_p;
    logic signed [63:0] err_c;
    logic             wr_status;
    logic             wr_clear;

    // magnitude of a two's complement word; -2^31 maps to 2^31
    function automatic logic [31:0] mag32(input logic signed [31:0] v);
        logic [31:0] r;
        r = v[31] ? (~v + 32'h0000_0001) : v;
        return r;
    endfunction : mag32

    // true when v lies outside the closed band -lim .. +lim
    function automatic logic out_of_band(
        input logic signed [63:0] v,
        input logic signed [63:0] lim
    );
        logic r;
        r = (v > lim) || (v < -lim);
        return r;
    endfunction : out_of_band

    // checks one group of four allocation bytes
    // returns {undefined, polarity conflict, duplicate}
    function automatic logic [2:0] check_group(
        input logic [31:0] grp,
        input logic [6:0]  fmax
    );
        logic              undef;
        logic              conflict;
        logic              dup;
        logic [ALLOC_FN_W-1:0] fi;
        logic [ALLOC_FN_W-1:0] fj;
        logic              pi;
        logic              pj;
        undef    = 1'b0;
        conflict = 1'b0;
        dup      = 1'b0;
        for (int i = 0; i < 4; i++) begin
            fi = grp[8*i +: ALLOC_FN_W];
            pi = grp[8*i + ALLOC_POL_BIT];
            if (fi > fmax) begin
                undef = 1'b1;
            end
            for (int j = i + 1; j < 4; j++) begin
                fj = grp[8*j +: ALLOC_FN_W];
                pj = grp[8*j + ALLOC_POL_BIT];
                // function 0 means the input is left unallocated
                if (fi != '0 && fi == fj) begin
                    if (pi == pj) begin
                        dup = 1'b1;
                    end else begin
                        conflict = 1'b1;
                    end
                end
            end
        end
        return {undef, conflict, dup};
    endfunction : check_group

    // lowest status bit wins when several faults are pending
    function automatic logic [31:0] pick_code(input logic [EVT_N-1:0] st);
        logic [31:0] c;
        c = 32'h0000_0000;
        for (int k = EVT_N - 1; k >= 0; k--) begin
            if (st[k]) begin
                c = EVT_CODES[32*k +: 32];
            end
        end
        return c;
    endfunction : pick_code

    assign speed_mag = mag32(MOTOR_SPEED);
    assign delta_mag = mag32(CMD_DELTA);
    assign err_p     = {{16{FOLLOW_ERR_PULSE[47]}}, FOLLOW_ERR_PULSE};
    assign err_c     = {{16{FOLLOW_ERR_CMD[47]}}, FOLLOW_ERR_CMD};
    assign ovf1      = out_of_band(ABS_POS_CMD, OVF1_LIM);
    assign ovf2      = out_of_band(err_p, OVF2_PULSE_LIM)
                     || out_of_band(err_c, OVF2_CMD_LIM);

    // allocation checks run from the stored settings every cycle,
    // so a bad setting keeps re-raising its fault until corrected
    assign grp_lo = check_group(state_r.alloc_lo, FUNC_MAX);
    assign grp_hi = check_group(state_r.alloc_hi, FUNC_MAX);

    always_comb begin
        events = '0;
        events[BIT_OVERSPEED2] = SAMPLE_VALID
                               && (speed_mag > state_r.speed_lim);
        events[BIT_CMD_ERR]    = SAMPLE_VALID
                               && (delta_mag > state_r.cmd_lim);
        events[BIT_CMD_GEN]    = CMD_CALC_FAULT;
        events[BIT_CNT_OVF1]   = SAMPLE_VALID && ovf1;
        events[BIT_CNT_OVF2]   = SAMPLE_VALID && ovf2;
        events[BIT_DUP_LO]     = grp_lo[0];
        events[BIT_DUP_HI]     = grp_hi[0];
        events[BIT_FNUM_LO]    = grp_lo[2] | grp_lo[1];
        events[BIT_FNUM_HI]    = grp_hi[2] | grp_hi[1];
    end

    assign wr_status = WR_STB && (ADDR == OFS_STATUS);
    assign wr_clear  = WR_STB && (ADDR == OFS_CLEAR) && WDATA[0];
    assign code_now  = state_r.code;

    always_comb begin
        state_nxt = state_r;

        // sticky faults: a new event in the clearing cycle survives
        if (wr_clear) begin
            state_nxt.status = '0;
        end else if (wr_status) begin
            state_nxt.status = state_r.status & ~WDATA[EVT_N-1:0];
        end
        state_nxt.status = state_nxt.status | events;
        // code is registered so the fault view comes straight from flops
        state_nxt.code   = pick_code(state_nxt.status);

        if (WR_STB) begin
            unique case (ADDR)
                OFS_MASK: begin
                    state_nxt.mask = WDATA[EVT_N-1:0];
                end
                OFS_SPEED_LIM: begin
                    state_nxt.speed_lim = WDATA;
                end
                OFS_CMD_LIM: begin
                    state_nxt.cmd_lim = WDATA;
                end
                OFS_ALLOC_LO: begin
                    state_nxt.alloc_lo = WDATA;
                end
                OFS_ALLOC_HI: begin
                    state_nxt.alloc_hi = WDATA;
                end
                default: begin
                end
            endcase
        end

        // read data stand for one cycle only, zero otherwise
        state_nxt.rdata = 32'h0000_0000;
        if (RD_STB) begin
            unique case (ADDR)
                OFS_STATUS: begin
                    state_nxt.rdata = {{(32-EVT_N){1'b0}}, state_r.status};
                end
                OFS_MASK: begin
                    state_nxt.rdata = {{(32-EVT_N){1'b0}}, state_r.mask};
                end
                OFS_CODE: begin
                    state_nxt.rdata = code_now;
                end
                OFS_SPEED_LIM: begin
                    state_nxt.rdata = state_r.speed_lim;
                end
                OFS_CMD_LIM: begin
                    state_nxt.rdata = state_r.cmd_lim;
                end
                OFS_ALLOC_LO: begin
                    state_nxt.rdata = state_r.alloc_lo;
                end
                OFS_ALLOC_HI: begin
                    state_nxt.rdata = state_r.alloc_hi;
                end
                default: begin
                    state_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_r.status    <= RST_STATUS;
            state_r.mask      <= RST_MASK;
            state_r.speed_lim <= RST_SPEED_LIM;
            state_r.cmd_lim   <= RST_CMD_LIM;
            state_r.alloc_lo  <= RST_ALLOC;
            state_r.alloc_hi  <= RST_ALLOC;
            state_r.rdata     <= 32'h0000_0000;
            state_r.code      <= RST_CODE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign RDATA        = state_r.rdata;
    assign IRQ          = |(state_r.status & state_r.mask);
    assign FAULT_ACTIVE = |state_r.status;
    assign FAULT_CODE   = code_now;

endmodule : scfm_top

// >>> testbench/scfm_checker_sva.sv
`timescale 1ns/1ps
module scfm_checker #(
    parameter logic [6:0] FUNC_MAX = 7'h28
) (
    input wire logic               CLK_SYS,
    input wire logic               RST_N,
    input wire logic [7:0]         ADDR,
    input wire logic [31:0]        WDATA,
    input wire logic               WR_STB,
    input wire logic               RD_STB,
    input wire logic [31:0]        RDATA,
    input wire logic               IRQ,
    input wire logic               SAMPLE_VALID,
    input wire logic signed [31:0] MOTOR_SPEED,
    input wire logic signed [31:0] CMD_DELTA,
    input wire logic               CMD_CALC_FAULT,
    input wire logic signed [63:0] ABS_POS_CMD,
    input wire logic signed [47:0] FOLLOW_ERR_PULSE,
    input wire logic signed [47:0] FOLLOW_ERR_CMD,
    input wire logic               FAULT_ACTIVE,
    input wire logic [31:0]        FAULT_CODE
);
    localparam logic signed [63:0] P31 = 64'sh0000_0000_8000_0000;
    localparam logic signed [47:0] P29 = 48'sh0000_2000_0000;
    localparam logic signed [47:0] P30 = 48'sh0000_4000_0000;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // a clear with no sample or command event beside it leaves only allocation faults
    sequence s_clr;
        WR_STB && ADDR == 8'h1C && WDATA[0] && !CMD_CALC_FAULT && !SAMPLE_VALID;
    endsequence
    sequence s_left;
        FAULT_CODE == 32'h0000_0000 || FAULT_CODE >= 32'h3845_0000;
    endsequence
    clear_all_a: assert property (s_clr |=> s_left)
        else $error("sample fault survived clear");
    gen_fault_a: assert property (CMD_CALC_FAULT
        |=> FAULT_ACTIVE && FAULT_CODE != 0 && FAULT_CODE <= 32'h3842_0000)
        else $error("command generation fault not latched");
    pos_ovf_a: assert property (SAMPLE_VALID && (ABS_POS_CMD > P31 || ABS_POS_CMD < -P31)
        |=> FAULT_ACTIVE && FAULT_CODE != 0 && FAULT_CODE <= 32'h3843_0000) else $error("position overflow missed");
    fol_ovf_a: assert property (SAMPLE_VALID && (FOLLOW_ERR_PULSE > P29 || FOLLOW_ERR_PULSE < -P29
        || FOLLOW_ERR_CMD > P30 || FOLLOW_ERR_CMD < -P30) |=> FAULT_ACTIVE && FAULT_CODE <= 32'h3844_0000)
        else $error("following error overflow missed");
    sticky_fault_a: assert property (FAULT_ACTIVE && !WR_STB |=> FAULT_ACTIVE)
        else $error("fault dropped without a write");
    irq_source_a: assert property (IRQ |-> FAULT_ACTIVE) else $error("interrupt without pending fault");
    idle_code_a: assert property (!FAULT_ACTIVE |-> FAULT_CODE == 0 && !IRQ) else $error("code while idle");
    read_idle_a: assert property (!RD_STB |=> RDATA == 0) else $error("read data without read");
endmodule : scfm_checker
bind scfm_top scfm_checker #(.FUNC_MAX(FUNC_MAX)) u_chk (.*);

// >>> testbench/scfm_host.sv
`timescale 1ns/1ps
module scfm_host (
    input  wire logic clk_sys,
    input  wire logic [31:0] rdata,
    output logic [7:0]  addr,
    output logic [31:0] wdata,
    output logic        wr_stb,
    output logic        rd_stb
);
    initial begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
endmodule : scfm_host

// >>> testbench/tb_servo_command_fault_monitor.sv
`timescale 1ns/1ps
module tb_servo_command_fault_monitor;
    import scfm_pkg::*;
    typedef struct {
        logic signed [31:0] spd;
        logic signed [31:0] dlt;
        logic               flt;
        logic signed [63:0] pos;
        logic signed [47:0] fep;
        logic signed [47:0] fec;
        int                 bit_n;
    } scfm_row_t;
    logic               clk_sys, rst_n, wr_stb, rd_stb, irq, sample_valid, cmd_calc_fault, fault_active;
    logic [7:0]         addr;
    logic [31:0]        wdata, rdata, fault_code, d;
    logic signed [31:0] motor_speed, cmd_delta;
    logic signed [63:0] abs_pos_cmd;
    logic signed [47:0] follow_err_pulse, follow_err_cmd;
    int                 num_errors, tests_run;
    scfm_row_t          rows[10];
    scfm_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RDATA(rdata), .IRQ(irq), .SAMPLE_VALID(sample_valid), .MOTOR_SPEED(motor_speed),
        .CMD_DELTA(cmd_delta), .CMD_CALC_FAULT(cmd_calc_fault), .ABS_POS_CMD(abs_pos_cmd),
        .FOLLOW_ERR_PULSE(follow_err_pulse), .FOLLOW_ERR_CMD(follow_err_cmd),
        .FAULT_ACTIVE(fault_active), .FAULT_CODE(fault_code));
    scfm_host host (.clk_sys(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
    task automatic final_report();
        $display("mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic smp(input scfm_row_t r);
        @(posedge clk_sys);
        motor_speed <= r.spd;
        cmd_delta <= r.dlt;
        abs_pos_cmd <= r.pos;
        follow_err_pulse <= r.fep;
        follow_err_cmd <= r.fec;
        cmd_calc_fault <= r.flt;
        sample_valid <= 1'b1;
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        cmd_calc_fault <= 1'b0;
        #1;
    endtask : smp
    // allocation faults re-arm every cycle, so the setting is undone before the clear
    task automatic alc(input logic [7:0] a, input logic [31:0] v, input logic [31:0] st);
        host.wr(a, v);
        host.rd(OFS_STATUS, d);
        chk(d, st);
        host.wr(a, 32'h0000_0000);
        host.wr(OFS_CLEAR, 32'h0000_0001);
        host.rd(OFS_STATUS, d);
        chk(d, 32'h0000_0000);
    endtask : alc
    initial begin
        {rst_n, sample_valid, cmd_calc_fault, motor_speed, cmd_delta} = '0;
        {abs_pos_cmd, follow_err_pulse, follow_err_cmd} = '0;
        rows = '{'{32'sh0000_03E8, 0, 0, 0, 0, 0, 15}, '{32'sh0000_03E9, 0, 0, 0, 0, 0, 0},
            '{32'shFFFF_FC17, 0, 0, 0, 0, 0, 0}, '{0, 32'sh0000_01F5, 0, 0, 0, 0, 1}, '{0, 0, 1, 0, 0, 0, 2},
            '{0, 0, 0, 64'sh8000_0000, 0, 0, 15}, '{0, 0, 0, 64'sh8000_0001, 0, 0, 3},
            '{0, 0, 0, 64'shFFFF_FFFF_7FFF_FFFF, 0, 0, 3}, '{0, 0, 0, 0, 48'sh2000_0001, 0, 4},
            '{0, 0, 0, 0, 0, 48'shFFFF_BFFF_FFFF, 4}};
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        host.rd(OFS_MASK, d);
        chk(d, 32'h0000_0000);
        host.rd(OFS_SPEED_LIM, d);
        chk(d, 32'hFFFF_FFFF);
        host.wr(OFS_SPEED_LIM, 32'h0000_03E8);
        host.wr(OFS_CMD_LIM, 32'h0000_01F4);
        foreach (rows[i]) begin
            smp(rows[i]);
            chk(fault_code, rows[i].bit_n < 9 ? 32'h3840_0000 + (rows[i].bit_n << 16) : 0);
            host.rd(OFS_STATUS, d);
            chk(d, rows[i].bit_n < 9 ? 1 << rows[i].bit_n : 0);
            host.wr(OFS_STATUS, 32'h0000_01FF);
            chk(32'(fault_active), 32'h0000_0000);
        end
        alc(OFS_ALLOC_LO, 32'h0000_0505, 32'h0000_0020);
        alc(OFS_ALLOC_HI, 32'h0505_0000, 32'h0000_0040);
        alc(OFS_ALLOC_LO, 32'h0000_7F00, 32'h0000_0080);
        alc(OFS_ALLOC_HI, 32'h2900_0000, 32'h0000_0100);
        alc(OFS_ALLOC_LO, 32'h0085_0005, 32'h0000_0080);
        alc(OFS_ALLOC_HI, 32'h0000_8505, 32'h0000_0100);
        alc(OFS_ALLOC_LO, 32'h2800_0000, 32'h0000_0000);
        host.wr(OFS_MASK, 32'h0000_0004);
        smp(rows[4]);
        chk(32'(irq), 32'h0000_0001);
        host.wr(OFS_CODE, 32'h0000_0000);
        host.rd(OFS_CODE, d);
        chk(d, 32'h3842_0000);
        host.rd(8'h20, d);
        chk(d, 32'h0000_0000);
        host.wr(OFS_STATUS, 32'h0000_0004);
        chk(32'(irq), 32'h0000_0000);
        smp(rows[1]);
        chk({irq, fault_active}, 32'h0000_0001);
        host.wr(OFS_MASK, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk({irq, fault_active}, 32'h0000_0000);
        host.rd(OFS_MASK, d);
        chk(d, 32'h0000_0000);
        final_report();
    end
endmodule : tb_servo_command_fault_monitor
